// file: core/urb_map.vh
// register map, field positions, reset values and timing counts of the serial receiver block
// assumes: included by the design files only, 32-bit apb data, byte addresses
`ifndef URB_MAP_VH
`define URB_MAP_VH
// ==========================================================
// register offsets
`define URB_OFS_STATUS 8'h00
`define URB_OFS_DATA   8'h04
`define URB_OFS_CTRL   8'h08
`define URB_OFS_BAUD   8'h0C
// ==========================================================
// status fields
`define URB_ST_PERR  0
`define URB_ST_NOISE 1
`define URB_ST_FERR  2
`define URB_ST_OVR   3
`define URB_ST_RIDLE 4
`define URB_ST_RAVL  5
`define URB_ST_TIDLE 6
`define URB_ST_TEMP  7
// ==========================================================
// control fields
`define URB_CT_RXON  0
`define URB_CT_NINE  1
`define URB_CT_PAR   2
`define URB_CT_ODD   3
`define URB_CT_STOP2 4
`define URB_CT_BRK   5
`define URB_CT_TX8   6
`define URB_CT_RX8   7
`define URB_CT_RIRQ  8
`define URB_CT_TIRQ  9
// ==========================================================
// reset values and timing counts
`define URB_CTRL_RST 10'h000
`define URB_BAUD_RST 16'h0004
`define URB_OSR      5'h10
`define URB_SMP_A    4'h7
`define URB_SMP_B    4'h8
`define URB_SMP_C    4'h9
`define URB_BRK_BITS 4'hD
`endif

// file: core/urb_top.v
// serial receiver with break generation, two-word receive fifo and error flags, apb slave
// assumes: one clock, serial input synchronous to sys_clk_i, apb master waits for pready
`timescale 1ns/10ps
`include "urb_map.vh"

// Function
// - status access then data write clears tx empty and tx idle flags.
// - break sends start bit then multiples of thirteen zero bits.
// - break transmission raises no transmit interrupt request.
// - break repeats while control set; after clearing, finish break, send stops.
// - nine-bit mode captures nine bits, top bit shown in ninth-bit field.
// - line sampled sixteen times per bit, shifter advances once per bit.
// - each bit decided by majority of three samples.
// - after stop sample, word moves to buffer when room exists.
// - serial data shifted in least significant bit first.
// - buffer holds two words; a third finding it full is dropped, overrun.
// - overrun sets flag, keeps buffer, overwrites shifter, requests receive interrupt.
// - enabled receiver hunts for a start bit.
// - data-available set while buffer holds a word; transfer requests interrupt.
// - available, overrun, noise clear only by status access then data read.
// - break is a framing error ending after data bits plus one stop.
// - after break or bad stop, wait for high line before hunting.
// - receiver idle low from start detection through stop sampling.
// - noise flag set with data available, word kept, no own interrupt.
// - zero at stop position sets framing flag; kept with the word, cleared when status read then data read removes it.
// - wrong received parity sets parity flag when parity enabled.
// - receiver checks a single stop bit whatever the stop setting.
module urb_top #(
    parameter BAUD_W = 16
) (
    input  wire        sys_clk_i,
    input  wire        nrst_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [7:0]  paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,
    input  wire        serial_in_pin_i,
    output reg         serial_out_pin_o,
    output reg         rx_irq_o,
    output reg         tx_irq_o
);
    // receiver states
    localparam [4:0] RX_HUNT  = 5'b00001;
    localparam [4:0] RX_START = 5'b00010;
    localparam [4:0] RX_DATA  = 5'b00100;
    localparam [4:0] RX_STOP  = 5'b01000;
    localparam [4:0] RX_WAIT  = 5'b10000;
    // transmitter states
    localparam [2:0] TX_IDLE  = 3'b001;
    localparam [2:0] TX_SHIFT = 3'b010;
    localparam [2:0] TX_BRK   = 3'b100;

    reg [9:0]        serial_ctrl_one;
    reg [BAUD_W-1:0] baud_divisor;
    reg [BAUD_W-1:0] baud_cnt;
    reg              tick;
    reg              status_armed;
    reg [4:0]        rx_state;
    reg [3:0]        rx_tick;
    reg [2:0]        rx_smp;
    reg              rx_last;
    reg [8:0]        rx_shifter;
    reg [3:0]        rx_bits;
    reg              rx_noise_acc;
    reg [10:0]       fifo_mem [0:1];
    reg              wr_ptr;
    reg              rd_ptr;
    reg [1:0]        fifo_cnt;
    reg              rx_avail_flag;
    reg              overrun_flag;
    reg              noise_flag;
    reg              rx_idle_flag;
    reg              tx_empty_flag;
    reg              tx_idle_flag;
    reg [8:0]        serial_data_buffer;
    reg [2:0]        tx_state;
    reg [3:0]        tx_tick;
    reg [11:0]       tx_shift;
    reg [3:0]        tx_left;
    reg [1:0]        tx_stops;

    wire       apb_done   = psel_i & penable_i & pready_o;
    wire       data_hit   = apb_done & (paddr_i == `URB_OFS_DATA);
    wire       data_rd    = data_hit & ~pwrite_i;
    wire       data_wr    = data_hit & pwrite_i;
    wire       seq_rd     = data_rd & status_armed;
    wire       nine_bit_sel    = serial_ctrl_one[`URB_CT_NINE];
    wire       parity_on       = serial_ctrl_one[`URB_CT_PAR];
    wire       parity_odd_even = serial_ctrl_one[`URB_CT_ODD];
    wire       break_send_ctl  = serial_ctrl_one[`URB_CT_BRK];
    wire       receiver_on     = serial_ctrl_one[`URB_CT_RXON];
    wire [10:0] fifo_head = fifo_mem[rd_ptr];
    wire        rx_ninth_bit = fifo_head[8];

    // majority of three samples and disagreement as noise
    wire maj   = (rx_smp[0] & rx_smp[1]) | (rx_smp[0] & rx_smp[2]) | (rx_smp[1] & rx_smp[2]);
    wire noisy = ~(&rx_smp) & (|rx_smp);
    wire decide = tick & (rx_tick == `URB_SMP_C + 4'h1);

    // assembled word, aligned to bit 0 whatever the length
    wire [8:0] rx_word = nine_bit_sel ? rx_shifter : {1'b0, rx_shifter[8:1]};
    wire       rx_par_in = nine_bit_sel ? rx_word[8] : rx_word[7];
    wire       rx_par_ok = nine_bit_sel ? (^rx_word[7:0]) : (^rx_word[6:0]);
    wire       rx_perr = parity_on & ((rx_par_ok ^ parity_odd_even) != rx_par_in);

    wire pop      = seq_rd & (fifo_cnt != 2'h0);
    wire rx_end   = (rx_state == RX_STOP) & decide;
    wire push     = rx_end & ((fifo_cnt != 2'h2) | pop);
    wire overrun  = rx_end & (fifo_cnt == 2'h2) & ~pop;

    // transmit word with parity replacing the top data bit
    wire       tx_par = (nine_bit_sel ? (^serial_data_buffer[7:0]) : (^serial_data_buffer[6:0]))
                        ^ parity_odd_even;
    wire [8:0] tx_word = nine_bit_sel ?
                         {parity_on ? tx_par : serial_ctrl_one[`URB_CT_TX8],
                          serial_data_buffer[7:0]} :
                         {1'b1, parity_on ? tx_par : serial_data_buffer[7],
                          serial_data_buffer[6:0]};
    wire       tx_bit_end = tick & (tx_tick == 4'hF);
    wire       tx_load  = (tx_state == TX_IDLE) & ~break_send_ctl & ~tx_empty_flag;
    wire       tx_fin   = tx_bit_end & (tx_left == 4'h1);

    // ==========================================================
    // apb slave
    // one wait state, then answer; unmapped address gives pslverr
    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h00000000;
        end else begin
            pready_o  <= psel_i & penable_i & ~pready_o;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h00000000;
            if (psel_i & penable_i & ~pready_o) begin
                if (paddr_i == `URB_OFS_STATUS) begin
                    prdata_o <= {24'h000000, tx_empty_flag, tx_idle_flag, rx_avail_flag,
                                 rx_idle_flag, overrun_flag, fifo_head[9] & rx_avail_flag,
                                 noise_flag, fifo_head[10] & rx_avail_flag};
                end else if (paddr_i == `URB_OFS_DATA) begin
                    prdata_o <= {24'h000000, fifo_head[7:0]};
                end else if (paddr_i == `URB_OFS_CTRL) begin
                    prdata_o <= {22'h000000, serial_ctrl_one[9:8], rx_ninth_bit,
                                 serial_ctrl_one[6:0]};
                end else if (paddr_i == `URB_OFS_BAUD) begin
                    prdata_o <= {{(32-BAUD_W){1'b0}}, baud_divisor};
                end else begin
                    pslverr_o <= 1'b1;
                end
            end
        end
    end

    // writable registers; a status access arms the clearing sequences
    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            serial_ctrl_one <= `URB_CTRL_RST;
            baud_divisor    <= `URB_BAUD_RST;
            status_armed    <= 1'b0;
        end else begin
            if (apb_done & pwrite_i & (paddr_i == `URB_OFS_CTRL))
                serial_ctrl_one <= {pwdata_i[9:8], 1'b0, pwdata_i[6:0]};
            if (apb_done & pwrite_i & (paddr_i == `URB_OFS_BAUD))
                baud_divisor <= pwdata_i[BAUD_W-1:0];
            if (apb_done & (paddr_i == `URB_OFS_STATUS))
                status_armed <= 1'b1;
            else if (data_hit)
                status_armed <= 1'b0;
        end
    end

    // ==========================================================
    // oversampling tick, sixteen per bit time
    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            baud_cnt <= {BAUD_W{1'b0}};
            tick     <= 1'b0;
        end else begin
            tick <= (baud_cnt == {BAUD_W{1'b0}});
            if (baud_cnt == {BAUD_W{1'b0}})
                baud_cnt <= baud_divisor;
            else
                baud_cnt <= baud_cnt - {{(BAUD_W-1){1'b0}}, 1'b1};
        end
    end

    // ==========================================================
    // receiver
    // rx_tick wraps every sixteen ticks; samples 7,8,9, vote taken at tick 10
    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_state     <= RX_HUNT;
            rx_tick      <= 4'h0;
            rx_smp       <= 3'h7;
            rx_last      <= 1'b1;
            rx_shifter   <= 9'h000;
            rx_bits      <= 4'h0;
            rx_noise_acc <= 1'b0;
            rx_idle_flag <= 1'b1;
        end else if (!receiver_on) begin
            rx_state     <= RX_HUNT;
            rx_idle_flag <= 1'b1;
            rx_last      <= 1'b1;
        end else if (tick) begin
            rx_last <= serial_in_pin_i;
            rx_tick <= rx_tick + 4'h1;
            if ((rx_tick == `URB_SMP_A) || (rx_tick == `URB_SMP_B) || (rx_tick == `URB_SMP_C))
                rx_smp <= {serial_in_pin_i, rx_smp[2:1]};
            case (rx_state)
                RX_HUNT: begin
                    if (rx_last & ~serial_in_pin_i) begin
                        rx_state     <= RX_START;
                        rx_tick      <= 4'h1;
                        rx_idle_flag <= 1'b0;
                        rx_noise_acc <= 1'b0;
                    end
                end
                RX_START: begin
                    if (rx_tick == `URB_SMP_C + 4'h1) begin
                        if (maj) begin
                            rx_state     <= RX_HUNT;
                            rx_idle_flag <= 1'b1;
                        end else begin
                            rx_state     <= RX_DATA;
                            rx_bits      <= nine_bit_sel ? 4'h9 : 4'h8;
                            rx_noise_acc <= noisy;
                        end
                    end
                end
                RX_DATA: begin
                    if (rx_tick == `URB_SMP_C + 4'h1) begin
                        rx_shifter   <= {maj, rx_shifter[8:1]};
                        rx_noise_acc <= rx_noise_acc | noisy;
                        rx_bits      <= rx_bits - 4'h1;
                        if (rx_bits == 4'h1)
                            rx_state <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (rx_tick == `URB_SMP_C + 4'h1) begin
                        rx_idle_flag <= 1'b1;
                        rx_state     <= maj ? RX_HUNT : RX_WAIT;
                    end
                end
                RX_WAIT: begin
                    if (serial_in_pin_i)
                        rx_state <= RX_HUNT;
                end
                default: rx_state <= RX_HUNT;
            endcase
        end
    end

    // ==========================================================
    // two-word receive fifo: {parity fault, framing, word}
    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fifo_mem[0] <= 11'h000;
            fifo_mem[1] <= 11'h000;
            wr_ptr      <= 1'b0;
            rd_ptr      <= 1'b0;
            fifo_cnt    <= 2'h0;
        end else begin
            if (push) begin
                // a bad stop loads the sampled zeros of a break as they are
                fifo_mem[wr_ptr] <= {rx_perr, ~maj, rx_word};
                wr_ptr           <= ~wr_ptr;
            end
            if (pop)
                rd_ptr <= ~rd_ptr;
            fifo_cnt <= fifo_cnt + {1'b0, push} - {1'b0, pop};
        end
    end

    // receive flags; a new event wins over the clearing read
    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_avail_flag <= 1'b0;
            overrun_flag  <= 1'b0;
            noise_flag    <= 1'b0;
            rx_irq_o      <= 1'b0;
        end else begin
            rx_avail_flag <= push | (fifo_cnt - {1'b0, pop} != 2'h0);
            if (overrun)
                overrun_flag <= 1'b1;
            else if (seq_rd)
                overrun_flag <= 1'b0;
            if (push & (rx_noise_acc | noisy))
                noise_flag <= 1'b1;
            else if (seq_rd)
                noise_flag <= 1'b0;
            rx_irq_o <= serial_ctrl_one[`URB_CT_RIRQ] & (push | overrun);
        end
    end

    // ==========================================================
    // transmitter with break generation
    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_state           <= TX_IDLE;
            tx_tick            <= 4'h0;
            tx_shift           <= 12'hFFF;
            tx_left            <= 4'h0;
            tx_stops           <= 2'h1;
            serial_out_pin_o   <= 1'b1;
            serial_data_buffer <= 9'h000;
            tx_empty_flag      <= 1'b1;
            tx_idle_flag       <= 1'b1;
            tx_irq_o           <= 1'b0;
        end else begin
            tx_irq_o <= 1'b0;
            tx_stops <= serial_ctrl_one[`URB_CT_STOP2] ? 2'h2 : 2'h1;
            if (data_wr & status_armed & tx_empty_flag) begin
                serial_data_buffer <= {1'b0, pwdata_i[7:0]};
                tx_empty_flag      <= 1'b0;
                tx_idle_flag       <= 1'b0;
            end
            if (tick & (tx_state != TX_IDLE))
                tx_tick <= tx_tick + 4'h1;
            case (tx_state)
                TX_IDLE: begin
                    serial_out_pin_o <= 1'b1;
                    tx_tick          <= 4'h0;
                    if (break_send_ctl) begin
                        tx_state <= TX_BRK;
                        tx_shift <= 12'h000;
                        tx_left  <= `URB_BRK_BITS + 4'h1;
                        tx_idle_flag <= 1'b0;
                    end else if (tx_load) begin
                        tx_state <= TX_SHIFT;
                        tx_shift <= {2'h3, tx_word, 1'b0};
                        tx_left  <= (nine_bit_sel ? 4'hA : 4'h9) + {2'h0, tx_stops};
                        tx_empty_flag <= 1'b1;
                        tx_irq_o <= serial_ctrl_one[`URB_CT_TIRQ];
                    end
                end
                TX_SHIFT: begin
                    serial_out_pin_o <= tx_shift[0];
                    if (tx_bit_end) begin
                        tx_shift <= {1'b1, tx_shift[11:1]};
                        tx_left  <= tx_left - 4'h1;
                        if (tx_fin) begin
                            tx_state     <= TX_IDLE;
                            tx_idle_flag <= 1'b1;
                        end
                    end
                end
                TX_BRK: begin
                    serial_out_pin_o <= 1'b0;
                    if (tx_bit_end) begin
                        tx_left <= tx_left - 4'h1;
                        if (tx_fin) begin
                            if (break_send_ctl) begin
                                tx_left <= `URB_BRK_BITS;
                            end else begin
                                // stop bits only, no data, no transmit request
                                tx_state <= TX_SHIFT;
                                tx_shift <= 12'hFFF;
                                tx_left  <= {2'h0, tx_stops};
                            end
                        end
                    end
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end
endmodule

// file: tb/urb_chk.sv
// checker for urb_top: apb answer timing, interrupt gating, transmit low-run lengths
// assumes: bound to urb_top, sees its ports only, one clock, async active-low reset
`timescale 1ns/10ps
module urb_chk (
    input wire        sys_clk_i,
    input wire        nrst_i,
    input wire        psel_i,
    input wire        penable_i,
    input wire        pwrite_i,
    input wire [7:0]  paddr_i,
    input wire [31:0] pwdata_i,
    input wire [31:0] prdata_o,
    input wire        pready_o,
    input wire        pslverr_o,
    input wire        serial_in_pin_i,
    input wire        serial_out_pin_o,
    input wire        rx_irq_o,
    input wire        tx_irq_o
);
    // ==========================================================
    // shadow of control and baud, length of the current low run on the line
    logic [9:0]  ctrl;
    logic [15:0] baud;
    logic [15:0] low_run;
    logic [20:0] bit_clks;
    wire         wr_ok = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;
    assign bit_clks = ({5'h00, baud} + 21'h000001) << 4;
    // writes land at the completing edge, as in the block itself
    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl    <= 10'h000;
            baud    <= 16'h0004;
            low_run <= 16'h0000;
        end else begin
            if (wr_ok && paddr_i == 8'h08)
                ctrl <= pwdata_i[9:0];
            if (wr_ok && paddr_i == 8'h0C)
                baud <= pwdata_i[15:0];
            low_run <= serial_out_pin_o ? 16'h0000 : low_run + 16'h0001;
        end
    end
    // ==========================================================
    // properties
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!nrst_i);
    pready_pulse_a:
        assert property (pready_o |=> !pready_o) else $error("pready held past one cycle");
    pready_wait_a:
        assert property (psel_i && penable_i && !$past(penable_i) |=> pready_o)
        else $error("pready not in second access cycle");
    rdata_quiet_a:
        assert property (!pready_o |-> prdata_o == 32'h00000000) else $error("stray read data");
    slverr_map_a:
        assert property (pready_o |-> pslverr_o == !(paddr_i inside {8'h00, 8'h04, 8'h08, 8'h0C}))
        else $error("error response does not match address map");
    slverr_ready_a:
        assert property (pslverr_o |-> pready_o) else $error("error response without ready");
    rx_irq_gate_a:
        assert property (rx_irq_o |-> $past(ctrl[8]) ##1 !rx_irq_o) else $error("bad rx irq");
    tx_irq_gate_a:
        assert property (tx_irq_o |-> $past(ctrl[9]) ##1 !tx_irq_o) else $error("bad tx irq");
    break_length_a:
        assert property ($rose(serial_out_pin_o) |-> (low_run % bit_clks == 0) &&
            ((low_run <= 10 * bit_clks) || ((low_run / bit_clks) % 13 == 1)))
        else $error("low run on transmit line has an illegal length");
endmodule

bind urb_top urb_chk urb_chk_i (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .serial_in_pin_i(serial_in_pin_i),
    .serial_out_pin_o(serial_out_pin_o), .rx_irq_o(rx_irq_o), .tx_irq_o(tx_irq_o)
);

// file: tb/urb_remote.sv
// remote serial station: sends frames and breaks to the block, receives its frames
// assumes: same clock as the block, bit time of BIT_CLKS clocks, line idles high
`timescale 1ns/10ps
module urb_remote #(
    parameter BIT_CLKS = 16
) (
    input  wire sys_clk_i,
    input  wire serial_out_pin_i,
    output reg  serial_in_pin_o
);
    // ==========================================================
    // line drivers
    initial serial_in_pin_o = 1'b1;
    // one bit time, optionally flipping one mid-bit sample to look like noise
    task automatic drive_bit(input logic v, input logic glitch);
        integer k;
        for (k = 0; k < BIT_CLKS; k = k + 1) begin
            @(posedge sys_clk_i);
            serial_in_pin_o <= (glitch && k == 8) ? ~v : v;
        end
    endtask
    // start, data lsb first, one stop of chosen level, then back to idle high
    task automatic send(input logic [8:0] d, input integer nb, input logic stop, input integer gl);
        integer i;
        drive_bit(1'b0, 1'b0);
        for (i = 0; i < nb; i = i + 1)
            drive_bit(d[i], gl == i);
        drive_bit(stop, 1'b0);
        if (stop !== 1'b1)
            drive_bit(1'b1, 1'b0);
    endtask
    // long low level, then a high bit so the receiver can hunt again
    task automatic brk(input integer nbits);
        integer i;
        for (i = 0; i < nbits; i = i + 1)
            drive_bit(1'b0, 1'b0);
        drive_bit(1'b1, 1'b0);
    endtask
    // catch one frame from the block, sampling each bit at its middle
    task automatic recv(output logic [8:0] d, input integer nb);
        integer i;
        d = 9'h000;
        for (i = 0; i < 2000 && serial_out_pin_i !== 1'b0; i = i + 1) @(posedge sys_clk_i);
        repeat (BIT_CLKS + BIT_CLKS / 2) @(posedge sys_clk_i);
        for (i = 0; i < nb; i = i + 1) begin
            d[i] = serial_out_pin_i;
            repeat (BIT_CLKS) @(posedge sys_clk_i);
        end
    endtask
endmodule

// file: tb/urb_tb_top.sv
// self-checking bench for the serial receiver block: apb tasks and frame scenarios
// assumes: urb_top, urb_chk and urb_remote compiled first; baud set to 0 (16 clocks a bit)
`timescale 1ns/10ps
module urb_tb_top;
    reg          sys_clk_i = 1'b0;
    reg          nrst_i    = 1'b0;
    reg          psel_i    = 1'b0;
    reg          penable_i = 1'b0;
    reg          pwrite_i  = 1'b0;
    reg  [7:0]   paddr_i   = 8'h00;
    reg  [31:0]  pwdata_i  = 32'h00000000;
    wire [31:0]  prdata_o;
    wire         pready_o;
    wire         pslverr_o;
    wire         serial_in_pin;
    wire         serial_out_pin;
    wire         rx_irq_o;
    wire         tx_irq_o;
    integer      n_errors    = 0;
    integer      check_count = 0;
    integer      i, k;
    logic [31:0] r;
    logic        err;
    logic [8:0]  d;
    // 10 MHz clock
    always #50 sys_clk_i = ~sys_clk_i;
    urb_top urb_top_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .serial_in_pin_i(serial_in_pin), .serial_out_pin_o(serial_out_pin),
        .rx_irq_o(rx_irq_o), .tx_irq_o(tx_irq_o));
    urb_remote #(.BIT_CLKS(16)) urb_remote_i (.sys_clk_i(sys_clk_i),
        .serial_out_pin_i(serial_out_pin), .serial_in_pin_o(serial_in_pin));
    // ==========================================================
    // shared tasks
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // one apb transfer; read data and error taken at the edge that sees pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        integer t;
        @(posedge sys_clk_i);
        psel_i   <= 1'b1;
        pwrite_i <= wr;
        paddr_i  <= a;
        pwdata_i <= wd;
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        for (t = 0; t < 16 && pready_o !== 1'b1; t = t + 1) @(posedge sys_clk_i);
        chk("apb answer", {31'h0, pready_o}, 32'h1);
        if (t == 16)
            results;
        r         = prdata_o;
        err       = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic wait_rx;
        for (k = 0; k < 400 && rx_irq_o !== 1'b1; k = k + 1) @(posedge sys_clk_i);
        chk("rx irq pulse", {31'h0, rx_irq_o}, 32'h1);
        if (k == 400)
            results;
    endtask
    // status, then data (pops the head), then status again with the fifo empty
    task automatic rd_frame(input logic [31:0] st, input logic [31:0] dat);
        apb(1'b0, 8'h00, 32'h0);
        chk("status", r, st);
        apb(1'b0, 8'h04, 32'h0);
        chk("data", r, dat);
        apb(1'b0, 8'h00, 32'h0);
        chk("status empty", r, 32'hD0);
    endtask
    // ==========================================================
    // main sequence
    initial begin
        repeat (12) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        chk("status reset", r, 32'hD0);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped error", {31'h0, err}, 32'h1);
        apb(1'b0, 8'h04, 32'h0);
        chk("data empty", r, 32'h0);
        apb(1'b1, 8'h0C, 32'h0);
        apb(1'b1, 8'h08, 32'h101);
        fork
            urb_remote_i.send(9'h0A5, 8, 1'b1, -1);
            wait_rx();
        join
        apb(1'b0, 8'h04, 32'h0);
        chk("data without status", r, 32'hA5);
        rd_frame(32'hF0, 32'hA5);
        $display("test single frame done");
        for (i = 0; i < 3; i = i + 1)
            urb_remote_i.send(9'h011 * (i + 1), 8, 1'b1, -1);
        apb(1'b0, 8'h00, 32'h0);
        chk("overrun status", r, 32'hF8);
        apb(1'b0, 8'h04, 32'h0);
        chk("oldest word kept", r, 32'h11);
        rd_frame(32'hF0, 32'h22);
        $display("test overrun done");
        fork
            urb_remote_i.send(9'h05A, 8, 1'b1, 0);
            begin
                repeat (60) @(posedge sys_clk_i);
                apb(1'b0, 8'h00, 32'h0);
                chk("idle low in frame", r, 32'hC0);
            end
        join
        rd_frame(32'hF2, 32'h5A);
        $display("test noise done");
        apb(1'b1, 8'h08, 32'h103);
        urb_remote_i.send(9'h1C3, 9, 1'b1, -1);
        apb(1'b0, 8'h08, 32'h0);
        chk("ninth bit", r, 32'h183);
        rd_frame(32'hF0, 32'hC3);
        for (i = 0; i < 2; i = i + 1) begin
            apb(1'b1, 8'h08, 32'h105 | (i << 3));
            urb_remote_i.send(9'h083, 8, 1'b1, -1);
            rd_frame(32'hF1 - i, 32'h83);
        end
        $display("test nine bit and parity done");
        apb(1'b1, 8'h08, 32'h101);
        urb_remote_i.brk(30);
        rd_frame(32'hF4, 32'h00);
        urb_remote_i.send(9'h07E, 8, 1'b0, -1);
        rd_frame(32'hF4, 32'h7E);
        urb_remote_i.send(9'h0E6, 8, 1'b1, -1);
        rd_frame(32'hF0, 32'hE6);
        $display("test receive break done");
        apb(1'b1, 8'h08, 32'h201);
        fork
            urb_remote_i.recv(d, 8);
            begin
                apb(1'b0, 8'h00, 32'h0);
                apb(1'b1, 8'h04, 32'h96);
                apb(1'b0, 8'h00, 32'h0);
                chk("tx flags after write", r & 32'hC0, 32'h80);
            end
        join
        chk("tx byte", {23'h0, d}, 32'h96);
        repeat (40) @(posedge sys_clk_i);
        i = 0;
        fork
            begin
                apb(1'b1, 8'h08, 32'h221);
                repeat (60) @(posedge sys_clk_i);
                apb(1'b1, 8'h08, 32'h201);
            end
            begin
                for (k = 0; k < 100 && serial_out_pin !== 1'b0; k = k + 1) @(posedge sys_clk_i);
                for (k = 0; k < 2000 && serial_out_pin !== 1'b1; k = k + 1) begin
                    @(posedge sys_clk_i);
                    if (tx_irq_o === 1'b1)
                        i = i + 1;
                end
            end
        join
        chk("break low length", k, 32'd224);
        chk("break tx irq", i, 32'd0);
        $display("test transmit done");
        results();
    end
endmodule
